// file: rtl/cgi_top.sv
// Interrupt logic of a dual-PLL clock generator: edge flags, mask, combine and status output.
// Assumes a synchronous single-cycle register port and sources synchronous to i_sys_clk.
//
// Functional notes
// - Polarity bit 1: rising edge of a source sets its sticky flag.
// - Polarity bit 0: falling edge of a source sets its sticky flag.
// - Polarity and flag bits ordered PLL A lock, signal, cal, PLL B same, switches.
// - Flags are only set while the interrupt enable bit is 1.
// - Combine bit 1: interrupt only when all unmasked flags are active.
// - Combine bit 0: interrupt when any unmasked flag is active.
// - Enable bit 0: no interrupt is signalled on the status output.
// - Live status tracks source levels regardless of the enable bit.
// - Alternate reference rise and fall valid read as bits 7 and 6.
// - Main reference rise and fall valid read as bits 5 and 4.
// - A mask bit of 1 keeps its flag out of the interrupt.
// - Live status shows present level of each source in flag bit order.
module cgi_top (
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_rst_n,
  input  wire cgi_pkg::cgi_src_t    i_src,
  input  wire cgi_pkg::cgi_ref_t    i_ref,
  input  wire cgi_pkg::cgi_reg_req_t i_reg,
  output logic [7:0]                o_reg_rdata,
  output logic                      o_status_irq
);

  logic       rst_meta_n;
  logic       rst_n;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  function automatic logic reg_hit(input cgi_pkg::cgi_reg_req_t req, input logic [7:0] addr);
    reg_hit = req.wr && (req.addr == addr);
  endfunction : reg_hit

  logic [7:0] live;
  logic [7:0] rise;
  logic [7:0] fall;
  logic [7:0] pol;
  logic [7:0] mask;
  logic [7:0] flag;
  logic [1:0] ctl;
  logic [3:0] ref_stat;
  logic       combined_req;

  cgi_edge_detect u_edge (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (rst_n),
    .i_src     (i_src),
    .o_live    (live),
    .o_rise    (rise),
    .o_fall    (fall)
  );

  wire       ctl_en   = ctl[cgi_pkg::CTL_EN_BIT];
  wire       ctl_and  = ctl[cgi_pkg::CTL_AND_BIT];
  wire       wr_pol   = reg_hit(i_reg, cgi_pkg::ADDR_POL);
  wire       wr_mask  = reg_hit(i_reg, cgi_pkg::ADDR_MASK);
  wire       wr_flag  = reg_hit(i_reg, cgi_pkg::ADDR_FLAG);
  wire       wr_ctl   = reg_hit(i_reg, cgi_pkg::ADDR_CTL);
  // Per-bit edge selection; same bit order as the live register
  wire [7:0] edge_hit = (rise & pol) | (fall & ~pol);
  wire [7:0] keep     = wr_flag ? i_reg.wdata : 8'hff;
  // Set wins over a clear in the same cycle so no event is lost
  wire [7:0] set_bits = ctl_en ? edge_hit : 8'h00;
  wire [7:0] next_flag = (flag & keep) | set_bits;
  wire [1:0] next_ctl  = wr_ctl ? i_reg.wdata[1:0] : ctl;
  wire [3:0] next_ref  = i_ref;

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pol  <= cgi_pkg::RST_POL;
      mask <= cgi_pkg::RST_MASK;
      flag <= cgi_pkg::RST_FLAG;
      ctl  <= cgi_pkg::RST_CTL;
    end else begin
      if (wr_pol) begin
        pol <= i_reg.wdata;
      end
      if (wr_mask) begin
        mask <= i_reg.wdata;
      end
      flag <= next_flag;
      ctl  <= next_ctl;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_stat <= cgi_pkg::RST_REF;
    end else begin
      ref_stat <= next_ref;
    end
  end

  cgi_combine u_combine (
    .i_flag    (flag),
    .i_mask    (mask),
    .i_and_sel (ctl_and),
    .i_en      (ctl_en),
    .o_req     (combined_req)
  );

  // Read decode; unmapped addresses read zero
  wire [7:0] rd_ctl = {6'h00, ctl};
  wire [7:0] rd_ref = {ref_stat, 4'h0};
  wire [7:0] next_rdata =
    (i_reg.addr == cgi_pkg::ADDR_LIVE) ? live :
    (i_reg.addr == cgi_pkg::ADDR_MASK) ? mask :
    (i_reg.addr == cgi_pkg::ADDR_POL)  ? pol  :
    (i_reg.addr == cgi_pkg::ADDR_FLAG) ? flag :
    (i_reg.addr == cgi_pkg::ADDR_CTL)  ? rd_ctl :
    (i_reg.addr == cgi_pkg::ADDR_REF)  ? rd_ref : cgi_pkg::RD_NONE;

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_reg_rdata  <= cgi_pkg::RD_NONE;
      o_status_irq <= 1'b0;
    end else begin
      o_reg_rdata  <= next_rdata;
      o_status_irq <= combined_req;
    end
  end

  // Checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!rst_n);

  a_rise_sets_flag: assert property (
    (ctl_en && |(rise & pol)) |=> ((flag & $past(rise & pol)) == $past(rise & pol)))
    else $error("rising edge did not set flag");

  a_fall_sets_flag: assert property (
    (ctl_en && |(fall & ~pol)) |=> ((flag & $past(fall & ~pol)) == $past(fall & ~pol)))
    else $error("falling edge did not set flag");

  a_wrong_edge_quiet: assert property (
    (!wr_flag && flag == 8'h00 && ctl_en && ((rise & ~pol) | (fall & pol)) != 8'h00
      && edge_hit == 8'h00) |=> (flag == 8'h00))
    else $error("edge of wrong polarity set a flag");

  a_flag_sticky: assert property (
    (!wr_flag) |=> ((flag & $past(flag)) == $past(flag)))
    else $error("flag fell without a clear write");

  a_write_clears: assert property (
    (wr_flag && !ctl_en) |=> (flag == ($past(flag) & $past(i_reg.wdata))))
    else $error("flag clear write wrong");

  a_disabled_no_set: assert property (
    (!ctl_en && !wr_flag) |=> (flag == $past(flag)))
    else $error("flag changed while disabled");

  a_and_combine: assert property (
    (ctl_en && ctl_and && (&(flag | mask)) && (mask != 8'hff)) |=> o_status_irq)
    else $error("AND combine missed interrupt");

  a_and_partial_quiet: assert property (
    (ctl_en && ctl_and && !(&(flag | mask))) |=> !o_status_irq)
    else $error("AND combine raised interrupt with a flag missing");

  a_or_combine: assert property (
    (ctl_en && !ctl_and && |(flag & ~mask)) |=> o_status_irq)
    else $error("OR combine missed interrupt");

  a_disabled_quiet: assert property (
    (!ctl_en) |=> !o_status_irq)
    else $error("interrupt while disabled");

  a_live_tracks: assert property (
    ##1 (i_reg.addr == cgi_pkg::ADDR_LIVE) ##1 1'b1 |-> (o_reg_rdata == $past(live)))
    else $error("live read wrong");

  a_live_follows_src: assert property (
    ##1 1'b1 |-> (live == $past(i_src)))
    else $error("live level lags source");

  a_ref_bits: assert property (
    (i_reg.addr == cgi_pkg::ADDR_REF) |=> (o_reg_rdata == {$past(ref_stat), 4'h0}))
    else $error("reference status read wrong");

  a_ref_sample: assert property (
    ##1 1'b1 |-> (ref_stat == $past(i_ref)))
    else $error("reference status not sampled");

  a_mask_blocks: assert property (
    (ctl_en && !ctl_and && ((flag & ~mask) == 8'h00)) |=> !o_status_irq)
    else $error("masked flag raised interrupt");

  a_ctl_reserved: assert property (
    (i_reg.addr == cgi_pkg::ADDR_CTL) |=> (o_reg_rdata[7:2] == 6'h00))
    else $error("reserved control bits not zero");

  c_or_irq:   cover property (ctl_en && !ctl_and ##1 o_status_irq);
  c_and_irq:  cover property (ctl_en && ctl_and ##1 o_status_irq);
  c_set_clr:  cover property (wr_flag && |(set_bits & ~i_reg.wdata));
  c_fall_set: cover property (ctl_en && |(fall & ~pol));

endmodule : cgi_top

// file: common/cgi_pkg.sv
// Constants, register map and carrier types for the clock generator interrupt logic.
// Assumes a single system clock domain; all register accesses are synchronous to it.
package cgi_pkg;

  // Register offsets (byte addresses on the internal register port)
  localparam logic [7:0] ADDR_LIVE = 8'h0d;
  localparam logic [7:0] ADDR_MASK = 8'h0e;
  localparam logic [7:0] ADDR_POL  = 8'h0f;
  localparam logic [7:0] ADDR_FLAG = 8'h10;
  localparam logic [7:0] ADDR_CTL  = 8'h11;
  localparam logic [7:0] ADDR_REF  = 8'h12;

  // Control register field positions
  localparam int CTL_EN_BIT  = 0;
  localparam int CTL_AND_BIT = 1;

  // Reference status field positions
  localparam int REF_ALT_RISE_BIT  = 7;
  localparam int REF_ALT_FALL_BIT  = 6;
  localparam int REF_MAIN_RISE_BIT = 5;
  localparam int REF_MAIN_FALL_BIT = 4;

  // Reset values
  localparam logic [7:0] RST_LIVE = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RST_POL  = 8'h00;
  localparam logic [7:0] RST_FLAG = 8'h00;
  localparam logic [1:0] RST_CTL  = 2'h0;
  localparam logic [3:0] RST_REF  = 4'h0;
  localparam logic [7:0] RD_NONE  = 8'h00;

  // Interrupt sources, bit 7 first
  typedef struct packed {
    logic pll_a_lock_lost;
    logic pll_a_signal_lost;
    logic pll_a_calibrating;
    logic pll_b_lock_lost;
    logic pll_b_signal_lost;
    logic pll_b_calibrating;
    logic pll_a_ref_switch_back;
    logic pll_b_ref_switch_back;
  } cgi_src_t;

  // Slew-rate detector indications, in register order bit 7 down to bit 4
  typedef struct packed {
    logic alt_ref_rise_ok;
    logic alt_ref_fall_ok;
    logic main_ref_rise_ok;
    logic main_ref_fall_ok;
  } cgi_ref_t;

  // One register port request per cycle
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic [7:0] wdata;
  } cgi_reg_req_t;

endpackage : cgi_pkg

// file: rtl/cgi_edge_detect.sv
// Samples the live sources and finds rising and falling edges per source.
// Assumes sources are synchronous to the system clock.
module cgi_edge_detect (
  input  wire logic            i_sys_clk,
  input  wire logic            i_rst_n,
  input  wire cgi_pkg::cgi_src_t i_src,
  output logic [7:0]           o_live,
  output logic [7:0]           o_rise,
  output logic [7:0]           o_fall
);

  logic [7:0] live;
  logic [7:0] prev;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      live <= cgi_pkg::RST_LIVE;
      prev <= cgi_pkg::RST_LIVE;
    end else begin
      live <= i_src;
      prev <= live;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_bit
      assign o_rise[g] = live[g] & ~prev[g];
      assign o_fall[g] = ~live[g] & prev[g];
    end
  endgenerate

  assign o_live = live;

endmodule : cgi_edge_detect

// file: rtl/cgi_combine.sv
// Combines unmasked flags by AND or OR into one interrupt request.
// Assumes flags and mask are registered upstream.
module cgi_combine (
  input  wire logic [7:0] i_flag,
  input  wire logic [7:0] i_mask,
  input  wire logic       i_and_sel,
  input  wire logic       i_en,
  output logic            o_req
);

  logic [7:0] active;
  logic       any_unmasked;
  logic       or_req;
  logic       and_req;

  assign active       = i_flag & ~i_mask;
  assign any_unmasked = |(~i_mask);
  assign or_req       = |active;
  // All sources masked gives no interrupt rather than an always-true AND
  assign and_req      = (&(i_flag | i_mask)) & any_unmasked;
  assign o_req        = i_en & (i_and_sel ? and_req : or_req);

endmodule : cgi_combine

// file: testbench/cgi_src_model.sv
// Far-side model: PLL status lines and slew-rate detector levels.
// Assumes the bench asks for new levels with a one-cycle load strobe.
module cgi_src_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_load,
  input  wire logic [7:0]  i_src_lvl,
  input  wire logic [3:0]  i_ref_lvl,
  output cgi_pkg::cgi_src_t o_src,
  output cgi_pkg::cgi_ref_t o_ref
);
  timeunit 1ns;
  timeprecision 1ps;
  // Status lines are levels held by the PLLs, so they never float
  initial begin
    o_src = '0;
    o_ref = '0;
  end
  always @(posedge i_sys_clk) begin
    if (i_load) begin
      o_src <= i_src_lvl;
      o_ref <= i_ref_lvl;
    end
  end
endmodule : cgi_src_model

// file: testbench/testbench.sv
// Self-checking bench for the interrupt logic with a reference model.
// Assumes cgi_pkg and the design files are compiled first.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  i_sys_clk = 1'b0;
  logic                  i_rst_n   = 1'b0;
  cgi_pkg::cgi_reg_req_t i_reg     = '0;
  cgi_pkg::cgi_src_t     src;
  cgi_pkg::cgi_ref_t     refl;
  logic [7:0]            o_reg_rdata;
  logic                  o_status_irq;
  logic                  load = 1'b0;
  logic [7:0]            src_lvl = 8'h00;
  logic [3:0]            ref_lvl = 4'h0;
  logic [7:0]            m_pol = 8'h00, m_mask = 8'h00, m_flag = 8'h00, m_live = 8'h00;
  logic [1:0]            m_ctl = 2'h0;
  logic [3:0]            m_ref = 4'h0;
  int                    failures = 0, check_count = 0, cycles = 0;
  logic [7:0]            addrs[$] = '{8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h3c};

  cgi_src_model i_cgi_src_model (.i_sys_clk(i_sys_clk), .i_load(load), .i_src_lvl(src_lvl),
    .i_ref_lvl(ref_lvl), .o_src(src), .o_ref(refl));
  cgi_top i_cgi_top (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_src(src), .i_ref(refl),
    .i_reg(i_reg), .o_reg_rdata(o_reg_rdata), .o_status_irq(o_status_irq));

  always #4 i_sys_clk = ~i_sys_clk;
  // Ceiling well above the roughly 2400 cycles the sequence needs
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  task automatic check(string name, logic [7:0] exp, logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge i_sys_clk);
    i_reg <= '{addr: a, wr: 1'b1, wdata: d};
    @(posedge i_sys_clk);
    i_reg.wr <= 1'b0;
    case (a)
      cgi_pkg::ADDR_MASK: m_mask = d;
      cgi_pkg::ADDR_POL:  m_pol = d;
      cgi_pkg::ADDR_FLAG: m_flag = m_flag & d;
      cgi_pkg::ADDR_CTL:  m_ctl = d[1:0];
      default: ;
    endcase
  endtask : wr

  task automatic rd(logic [7:0] a, logic [7:0] exp, string name);
    @(posedge i_sys_clk);
    i_reg <= '{addr: a, wr: 1'b0, wdata: 8'h00};
    repeat (2) @(posedge i_sys_clk);
    #1;
    check(name, exp, o_reg_rdata);
  endtask : rd

  // Edges are judged against the previous level, as the flags see them
  task automatic drive(logic [7:0] s, logic [3:0] r);
    @(posedge i_sys_clk);
    load <= 1'b1;
    src_lvl <= s;
    ref_lvl <= r;
    @(posedge i_sys_clk);
    load <= 1'b0;
    if (m_ctl[0]) m_flag = m_flag | (m_pol & s & ~m_live) | (~m_pol & ~s & m_live);
    m_live = s;
    m_ref = r;
    repeat (4) @(posedge i_sys_clk);
  endtask : drive

  function automatic logic exp_irq();
    if (!m_ctl[0]) return 1'b0;
    if (m_ctl[1]) return (m_mask != 8'hff) && ((m_flag | m_mask) == 8'hff);
    return (m_flag & ~m_mask) != 8'h00;
  endfunction : exp_irq

  task automatic check_all();
    rd(cgi_pkg::ADDR_LIVE, m_live, "live");
    rd(cgi_pkg::ADDR_FLAG, m_flag, "flag");
    rd(cgi_pkg::ADDR_REF, {m_ref, 4'h0}, "ref");
    rd(cgi_pkg::ADDR_MASK, m_mask, "mask");
    rd(cgi_pkg::ADDR_POL, m_pol, "pol");
    rd(cgi_pkg::ADDR_CTL, {6'h00, m_ctl}, "ctl");
    check("irq", {7'h00, exp_irq()}, {7'h00, o_status_irq});
  endtask : check_all

  initial begin
    void'($urandom(16));
    repeat (5) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    foreach (addrs[k]) rd(addrs[k], 8'h00, "reset");
    $display("test reset done");
    wr(cgi_pkg::ADDR_POL, 8'ha5);
    rd(cgi_pkg::ADDR_POL, 8'ha5, "pol");
    wr(cgi_pkg::ADDR_CTL, 8'hfc);
    rd(cgi_pkg::ADDR_CTL, 8'h00, "ctl");
    wr(cgi_pkg::ADDR_REF, 8'hff);
    wr(cgi_pkg::ADDR_LIVE, 8'hff);
    wr(8'h3c, 8'hff);
    foreach (addrs[k]) if (k != 2) rd(addrs[k], 8'h00, "ro");
    $display("test access done");
    drive(8'hff, 4'h0);
    check_all();
    drive(8'h00, 4'h0);
    check_all();
    $display("test disabled done");
    for (int n = 0; n < 60; n++) begin
      wr(cgi_pkg::ADDR_CTL, {6'h2a, n >= 30, n % 8 != 7});
      wr(cgi_pkg::ADDR_POL, 8'($urandom));
      wr(cgi_pkg::ADDR_MASK, (n % 4 == 0) ? 8'h00 : 8'($urandom));
      drive(8'($urandom), 4'($urandom));
      check_all();
      if (n % 3 == 2) begin
        wr(cgi_pkg::ADDR_FLAG, 8'($urandom));
        check_all();
      end
    end
    $display("test random done");
    wr(cgi_pkg::ADDR_CTL, 8'h03);
    wr(cgi_pkg::ADDR_FLAG, 8'h00);
    wr(cgi_pkg::ADDR_MASK, 8'hf0);
    wr(cgi_pkg::ADDR_POL, 8'h0f);
    drive(8'h00, 4'h5);
    drive(8'h0f, 4'ha);
    check_all();
    wr(cgi_pkg::ADDR_FLAG, 8'hfe);
    check_all();
    wr(cgi_pkg::ADDR_MASK, 8'hff);
    check_all();
    wr(cgi_pkg::ADDR_MASK, 8'h00);
    wr(cgi_pkg::ADDR_CTL, 8'h00);
    check_all();
    $display("test combine done");
    // Reset in mid-run: pol, mask, flag and ctl return to zero, live and ref pick up the held source and reference levels
    @(posedge i_sys_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    m_pol = 8'h00;
    m_mask = 8'h00;
    m_flag = 8'h00;
    m_ctl = 2'h0;
    check_all();
    $display("test reset again done");
    finish_test();
  end
endmodule : testbench
